// ---- otpps_map.svh ----
// Offsets, field positions, reset values and scale constants of the OTP store.
// Included by the package user; definitions only.
`ifndef OTPPS_MAP_SVH
`define OTPPS_MAP_SVH

// -----------------------------------------------------------------------------
// Byte offsets of the eight-byte store
// -----------------------------------------------------------------------------
`define OTPPS_OFS_TRIM_A    3'h0
`define OTPPS_OFS_TRIM_B    3'h1
`define OTPPS_OFS_STALL_ABS 3'h2
`define OTPPS_OFS_CURRENT   3'h3
`define OTPPS_OFS_SPEED     3'h4
`define OTPPS_OFS_FB_HIGH   3'h5
`define OTPPS_OFS_FB_LOW    3'h6
`define OTPPS_OFS_LOCKS     3'h7
`define OTPPS_OFS_LAST_FAB  3'h1

// -----------------------------------------------------------------------------
// Bit positions inside the lock byte and the fallback bytes
// -----------------------------------------------------------------------------
`define OTPPS_BIT_GLOBAL_LOCK  0
`define OTPPS_BIT_FACTORY_LOCK 1
`define OTPPS_BIT_SHAFT        4

// -----------------------------------------------------------------------------
// Reset values and scales
// -----------------------------------------------------------------------------
`define OTPPS_ADDR_PREFIX    2'h3
`define OTPPS_ABS_STEP_MV    13'h01F4
`define OTPPS_DEL_STEP_MV    12'h0FA
`define OTPPS_HOLD_OFF_CODE  4'hF
`define OTPPS_BYTE_ZERO      8'h00

`endif

// ---- otpps_pkg.sv ----
// Types shared by the OTP parameter store: commands, parameters, flags, states.
// Assumes nothing of its surroundings.
package otpps_pkg;

  typedef enum logic [2:0] {
    CMD_STATUS_READ,
    CMD_NVM_PROGRAM,
    CMD_NVM_READBACK,
    CMD_RESTORE_DEFAULTS,
    CMD_MOTION_WRITE
  } otpps_cmd_e_t;

  typedef struct packed {
    logic [3:0]  run_current;
    logic [3:0]  hold_current;
    logic [3:0]  vmax;
    logic [3:0]  vmin;
    logic        shaft;
    logic [3:0]  accel;
    logic [10:0] fallback_position_field;
    logic [1:0]  microstep_resolution;
    logic [3:0]  stall_abs_level;
    logic [3:0]  stall_delta_level;
  } otpps_params_t;

  typedef struct packed {
    otpps_cmd_e_t  code;
    logic [2:0]    addr;
    logic [7:0]    byte_data;
    otpps_params_t params;
  } otpps_cmd_t;

  typedef struct packed {
    logic thermal_warning_flag;
    logic thermal_shutdown_flag;
    logic battery_undervoltage_flag;
    logic lost_step_flag;
  } otpps_flags_t;

  typedef struct packed {
    logic [7:0]   byte_data;
    logic         refused;
    otpps_flags_t flags;
  } otpps_rsp_t;

  typedef enum logic [1:0] {
    TH_RUN,
    TH_HALTING,
    TH_SHUTDOWN
  } otpps_therm_e_t;

endpackage

// ---- otpps_top.sv ----
// OTP parameter store with lock bits, working registers and sticky protection flags.
// Commands arrive on the link clock from the bus controller; comparator levels
// come from analog pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "otpps_map.svh"

module otpps_top #(
  parameter logic [7:0] FACTORY_TRIM_A = 8'h00,   // Arbitrary calibration value
  parameter logic [7:0] FACTORY_TRIM_B = 8'h00    // Arbitrary calibration value
) (
  input  wire logic                    clk,              // Core clock, 25 MHz
  input  wire logic                    sys_rst,          // Synchronous reset, high
  input  wire logic                    link_clk,         // Command link clock
  input  wire otpps_pkg::otpps_cmd_t   cmd_in,           // Command from bus controller
  input  wire logic                    cmd_valid,        // Command offered
  output logic                         cmd_ready,        // Command may be taken
  output otpps_pkg::otpps_rsp_t        rsp_out,          // Answer to last command
  output logic                         rsp_valid,        // Answer pulse, link clock
  input  wire logic                    factory_init,     // Write factory image
  input  wire logic                    temp_warn_cmp,    // Die above warning level
  input  wire logic                    temp_sd_cmp,      // Die above shutdown level
  input  wire logic                    vbat_uv_cmp,      // Battery below threshold
  input  wire logic                    vbat_sd_cmp,      // Battery below shutdown level
  input  wire logic                    vbat_recov_cmp,   // Battery above recovery level
  input  wire logic                    strap_address_pin,// Strap address level
  input  wire logic                    motion_active,    // Motion in progress
  output logic                         decelerating_halt,// Halt request pulse
  output logic                         motor_shutdown,   // Motor outputs off
  output otpps_pkg::otpps_flags_t      flags_out,        // Sticky flags
  output otpps_pkg::otpps_params_t     work_params,      // Working parameters
  output logic [6:0]                   bus_address,      // Bus address
  output logic                         stall_abs_en,     // Absolute detection on
  output logic [12:0]                  stall_abs_mv,     // Absolute level, mV
  output logic                         stall_delta_en,   // Delta detection on
  output logic [11:0]                  stall_delta_mv,   // Delta level, mV
  output logic [9:0]                   run_current_ma,   // Run peak current, mA
  output logic [9:0]                   hold_current_ma,  // Hold current, mA
  output logic [4:0]                   microsteps        // Microsteps per full step
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [9:0] current_ma(input logic [3:0] code);
    case (code)
      4'h0: current_ma = 10'h03B;
      4'h1: current_ma = 10'h047;
      4'h2: current_ma = 10'h054;
      4'h3: current_ma = 10'h064;
      4'h4: current_ma = 10'h077;
      4'h5: current_ma = 10'h08D;
      4'h6: current_ma = 10'h0A8;
      4'h7: current_ma = 10'h0C8;
      4'h8: current_ma = 10'h0EE;
      4'h9: current_ma = 10'h11B;
      4'hA: current_ma = 10'h150;
      4'hB: current_ma = 10'h190;
      4'hC: current_ma = 10'h1DC;
      4'hD: current_ma = 10'h236;
      4'hE: current_ma = 10'h2A1;
      default: current_ma = 10'h320;
    endcase
  endfunction

  function automatic otpps_pkg::otpps_params_t unpack_nvm(input logic [7:0] b2, input logic [7:0] b3,
                                                        input logic [7:0] b4, input logic [7:0] b5,
                                                        input logic [7:0] b6, input logic [7:0] b7);
    otpps_pkg::otpps_params_t p;
    p.run_current             = b3[7:4];
    p.hold_current            = b3[3:0];
    p.vmax                    = b4[7:4];
    p.vmin                    = b4[3:0];
    p.shaft                   = b5[`OTPPS_BIT_SHAFT];
    p.accel                   = b5[3:0];
    p.fallback_position_field = {b5[7:5], b6[7:2], 2'h0};
    p.microstep_resolution    = b7[3:2];
    p.stall_abs_level         = b2[7:4];
    p.stall_delta_level       = b7[7:4];
    unpack_nvm = p;
  endfunction

  // ---------------------------------------------------------------------------
  // Link domain: command capture and answer
  // ---------------------------------------------------------------------------
  logic                   link_rst_s1_reg;
  logic                   link_rst_reg;
  logic                   link_busy_reg;
  logic                   req_tgl_reg;
  logic                   ack_s1_reg;
  logic                   ack_s2_reg;
  logic                   ack_s3_reg;
  otpps_pkg::otpps_cmd_t  cmd_hold_reg;
  otpps_pkg::otpps_rsp_t  rsp_hold_reg;
  logic                   ack_tgl_reg;

  // Reset release is re-timed so the link logic never sees a half-released reset
  always_ff @(posedge link_clk)
  begin
    link_rst_s1_reg <= sys_rst;
    link_rst_reg    <= link_rst_s1_reg;
  end

  assign cmd_ready = ~link_busy_reg & ~link_rst_reg;

  // One command in flight; the held word is stable until the core answers
  always_ff @(posedge link_clk)
  begin
    if (link_rst_reg)
    begin
      link_busy_reg <= 1'b0;
      req_tgl_reg   <= 1'b0;
      cmd_hold_reg  <= '0;
    end
    else if (cmd_valid && cmd_ready)
    begin
      link_busy_reg <= 1'b1;
      req_tgl_reg   <= ~req_tgl_reg;
      cmd_hold_reg  <= cmd_in;
    end
    else if (ack_s2_reg != ack_s3_reg)
    begin
      link_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst_reg)
    begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_out    <= '0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      rsp_valid  <= ack_s2_reg != ack_s3_reg;
      if (ack_s2_reg != ack_s3_reg)
        rsp_out <= rsp_hold_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Core domain: input synchronisers and command event
  // ---------------------------------------------------------------------------
  logic [6:0] pin_s1_reg;
  logic [6:0] pin_s2_reg;
  logic       req_s3_reg;
  logic       temp_warn_s;
  logic       temp_sd_s;
  logic       vbat_uv_s;
  logic       vbat_sd_s;
  logic       vbat_recov_s;
  logic       strap_s;
  logic       req_s2;
  logic       cmd_evt;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1_reg <= 7'h00;
      pin_s2_reg <= 7'h00;
      req_s3_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {req_tgl_reg, strap_address_pin, vbat_recov_cmp, vbat_sd_cmp, vbat_uv_cmp,
                     temp_sd_cmp, temp_warn_cmp};
      pin_s2_reg <= pin_s1_reg;
      req_s3_reg <= req_s2;
    end
  end

  assign {req_s2, strap_s, vbat_recov_s, vbat_sd_s, vbat_uv_s, temp_sd_s, temp_warn_s} = pin_s2_reg;
  assign cmd_evt = req_s2 != req_s3_reg;

  logic status_evt;
  logic prog_evt;
  logic mw_evt;
  logic copy_evt;
  logic glock;
  logic flock;
  logic prog_blocked;
  logic load_pending_reg;

  assign status_evt = cmd_evt && cmd_hold_reg.code == otpps_pkg::CMD_STATUS_READ;
  assign prog_evt   = cmd_evt && cmd_hold_reg.code == otpps_pkg::CMD_NVM_PROGRAM;
  assign mw_evt     = cmd_evt && cmd_hold_reg.code == otpps_pkg::CMD_MOTION_WRITE;
  // Power-up copy is deferred one cycle so the store is read after reset
  assign copy_evt   = load_pending_reg ||
                      (cmd_evt && (cmd_hold_reg.code == otpps_pkg::CMD_NVM_READBACK ||
                                   cmd_hold_reg.code == otpps_pkg::CMD_RESTORE_DEFAULTS));

  // ---------------------------------------------------------------------------
  // Store array and programming
  // ---------------------------------------------------------------------------
  logic [7:0]  nvm_mem [0:7];
  logic [63:0] nvm_flat;

  assign nvm_flat = {nvm_mem[7], nvm_mem[6], nvm_mem[5], nvm_mem[4],
                     nvm_mem[3], nvm_mem[2], nvm_mem[1], nvm_mem[0]};
  assign glock = nvm_mem[`OTPPS_OFS_LOCKS][`OTPPS_BIT_GLOBAL_LOCK];
  assign flock = nvm_mem[`OTPPS_OFS_LOCKS][`OTPPS_BIT_FACTORY_LOCK];
  assign prog_blocked = glock || (flock && cmd_hold_reg.addr <= `OTPPS_OFS_LAST_FAB);

  // Fuses survive sys_rst; the factory image load rewrites the array, an unblocked program command ORs bits into one byte
  always_ff @(posedge clk)
  begin
    if (factory_init)
    begin
      for (int i = 0; i < 8; i++)
        nvm_mem[i] <= `OTPPS_BYTE_ZERO;
      nvm_mem[`OTPPS_OFS_TRIM_A] <= FACTORY_TRIM_A;
      nvm_mem[`OTPPS_OFS_TRIM_B] <= FACTORY_TRIM_B;
      nvm_mem[`OTPPS_OFS_LOCKS]  <= 8'h02;
    end
    else if (prog_evt && !prog_blocked)
    begin
      // OR-in: a bit already at one cannot be cleared or re-zapped
      nvm_mem[cmd_hold_reg.addr] <= nvm_mem[cmd_hold_reg.addr] | cmd_hold_reg.byte_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Working registers
  // ---------------------------------------------------------------------------
  otpps_pkg::otpps_params_t work_reg;
  logic [3:0]               node_addr_bits_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      load_pending_reg <= 1'b1;
    else
      load_pending_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      work_reg           <= '0;
      node_addr_bits_reg <= 4'h0;
    end
    else if (copy_evt)
    begin
      work_reg           <= unpack_nvm(nvm_mem[2], nvm_mem[3], nvm_mem[4],
                                       nvm_mem[5], nvm_mem[6], nvm_mem[7]);
      node_addr_bits_reg <= nvm_mem[`OTPPS_OFS_STALL_ABS][3:0];
    end
    else if (mw_evt)
    begin
      work_reg <= cmd_hold_reg.params;
    end
  end

  assign work_params = work_reg;

  // ---------------------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ---------------------------------------------------------------------------
  otpps_pkg::otpps_flags_t flags_reg;
  logic                    tsd_set;

  assign tsd_set = temp_sd_s;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_reg <= '0;
    else
    begin
      if (temp_warn_s)
        flags_reg.thermal_warning_flag <= 1'b1;
      else if (status_evt)
        flags_reg.thermal_warning_flag <= 1'b0;
      if (tsd_set)
        flags_reg.thermal_shutdown_flag <= 1'b1;
      else if (status_evt && !temp_warn_s)
        flags_reg.thermal_shutdown_flag <= 1'b0;
      if (vbat_uv_s)
        flags_reg.battery_undervoltage_flag <= 1'b1;
      else if (status_evt && vbat_recov_s)
        flags_reg.battery_undervoltage_flag <= 1'b0;
      if (vbat_sd_s && motion_active)
        flags_reg.lost_step_flag <= 1'b1;
      else if (status_evt && vbat_recov_s)
        flags_reg.lost_step_flag <= 1'b0;
    end
  end

  assign flags_out = flags_reg;

  // ---------------------------------------------------------------------------
  // Answer to the link; held until the next command
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_hold_reg <= '0;
      ack_tgl_reg  <= 1'b0;
    end
    else if (cmd_evt)
    begin
      rsp_hold_reg.byte_data <= nvm_mem[cmd_hold_reg.addr];
      rsp_hold_reg.refused   <= prog_evt && prog_blocked;
      rsp_hold_reg.flags     <= flags_reg;
      ack_tgl_reg            <= ~ack_tgl_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Thermal shutdown sequencing
  // ---------------------------------------------------------------------------
  otpps_pkg::otpps_therm_e_t th_state_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      th_state_reg      <= otpps_pkg::TH_RUN;
      decelerating_halt <= 1'b0;
      motor_shutdown    <= 1'b0;
    end
    else
    begin
      decelerating_halt <= 1'b0;
      case (th_state_reg)
        otpps_pkg::TH_RUN:
          if (tsd_set)
          begin
            th_state_reg      <= otpps_pkg::TH_HALTING;
            decelerating_halt <= 1'b1;
          end
        otpps_pkg::TH_HALTING:
          if (!motion_active)
          begin
            th_state_reg   <= otpps_pkg::TH_SHUTDOWN;
            motor_shutdown <= 1'b1;
          end
        default:
          if (!flags_reg.thermal_shutdown_flag)
          begin
            th_state_reg   <= otpps_pkg::TH_RUN;
            motor_shutdown <= 1'b0;
          end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Decoded operating values
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_address     <= 7'h00;
      stall_abs_en    <= 1'b0;
      stall_abs_mv    <= 13'h0000;
      stall_delta_en  <= 1'b0;
      stall_delta_mv  <= 12'h000;
      run_current_ma  <= 10'h000;
      hold_current_ma <= 10'h000;
      microsteps      <= 5'h02;
    end
    else
    begin
      bus_address     <= {`OTPPS_ADDR_PREFIX, node_addr_bits_reg, strap_s};
      stall_abs_en    <= work_reg.stall_abs_level != 4'h0;
      stall_abs_mv    <= 13'(work_reg.stall_abs_level * `OTPPS_ABS_STEP_MV);
      stall_delta_en  <= work_reg.stall_delta_level != 4'h0;
      stall_delta_mv  <= 12'(work_reg.stall_delta_level * `OTPPS_DEL_STEP_MV);
      run_current_ma  <= current_ma(work_reg.run_current);
      hold_current_ma <= (work_reg.hold_current == `OTPPS_HOLD_OFF_CODE) ? 10'h000 :
                         current_ma(work_reg.hold_current);
      microsteps      <= 5'(5'h02 << work_reg.microstep_resolution);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [3:0] chk_abs_code;
  assign chk_abs_code = work_reg.stall_abs_level;

  a_global_lock_hold: assert property (prog_evt && glock && !factory_init |=> $stable(nvm_flat))
    else $error("store changed under global lock");
  a_factory_lock_hold: assert property (prog_evt && flock && cmd_hold_reg.addr <= 3'h1 && !factory_init
                                        |=> $stable(nvm_flat))
    else $error("trim bytes changed under factory lock");
  a_locked_no_side: assert property (prog_evt && prog_blocked |=> $stable(work_reg) && rsp_hold_reg.refused)
    else $error("locked program disturbed state");
  a_bits_only_set: assert property (!factory_init |=> ($past(nvm_flat) & ~nvm_flat) == 64'h0)
    else $error("stored bit went from one to zero");
  a_copy_only: assert property (!copy_evt && !mw_evt |=> $stable(work_reg))
    else $error("working registers changed without copy");
  a_node_addr_src: assert property (!copy_evt |=> $stable(node_addr_bits_reg))
    else $error("node address changed without copy");
  a_thermal_sticky: assert property (flags_reg.thermal_warning_flag && !status_evt
                                     |=> flags_reg.thermal_warning_flag)
    else $error("thermal warning cleared without status read");
  a_battery_sticky: assert property (flags_reg.battery_undervoltage_flag && !(status_evt && vbat_recov_s)
                                     |=> flags_reg.battery_undervoltage_flag)
    else $error("undervoltage cleared without recovery read");
  a_warn_set_wins: assert property (temp_warn_s |=> flags_reg.thermal_warning_flag)
    else $error("thermal warning not set");
  a_tsd_halt_seq: assert property (th_state_reg == otpps_pkg::TH_RUN && tsd_set
                                   |=> decelerating_halt ##1 !decelerating_halt)
    else $error("halt pulse not issued on shutdown");
  a_abs_level_scale: assert property (1'b1 |=> stall_abs_mv == 13'($past(chk_abs_code) * 13'h01F4))
    else $error("absolute level scale wrong");
  a_hold_off_code: assert property (work_reg.hold_current == 4'hF |=> hold_current_ma == 10'h000)
    else $error("hold code fifteen not zero current");

  c_prog_accepted: cover property (prog_evt && !prog_blocked);
  c_prog_refused:  cover property (prog_evt && prog_blocked);
  c_status_clear:  cover property (flags_reg.thermal_warning_flag ##1 !flags_reg.thermal_warning_flag);
  c_shutdown_done: cover property (th_state_reg == otpps_pkg::TH_SHUTDOWN);

endmodule
`default_nettype wire

// ---- otpps_mst.sv ----
// Bus controller model that offers one command at a time to the OTP store.
// Assumes a command is taken on a link edge that sees valid and ready high.
`timescale 1ns/1ps
`default_nettype none
module otpps_mst (
  input  wire logic             link_clk,  // Link clock
  input  wire logic             cmd_ready, // Take allowed
  input  wire logic             rsp_valid, // Answer pulse
  output otpps_pkg::otpps_cmd_t cmd_in,    // Offered command
  output logic                  cmd_valid  // Offer strobe
);
  initial
  begin
    cmd_in = '0;
    cmd_valid = 1'b0;
  end
  // Released data is inverted so a late sample cannot pass as fresh
  task automatic issue(input otpps_pkg::otpps_cmd_t c, output logic ok);
    int n;
    @(posedge link_clk);
    #1 cmd_in = c;
    cmd_valid = 1'b1;
    for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge link_clk);
    @(posedge link_clk);
    #1 cmd_valid = 1'b0;
    cmd_in = ~c;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge link_clk);
    ok = rsp_valid;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Bench: program, lock, copy and flag scenarios for the OTP store.
// Assumes otpps_top and the controller model otpps_mst.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] TRIM = 8'h5A; // Arbitrary trim value
  localparam otpps_pkg::otpps_cmd_e_t PRG = otpps_pkg::CMD_NVM_PROGRAM;
  localparam otpps_pkg::otpps_cmd_e_t RDB = otpps_pkg::CMD_NVM_READBACK;
  localparam otpps_pkg::otpps_cmd_e_t STS = otpps_pkg::CMD_STATUS_READ;
  logic clk, link_clk, sys_rst, factory_init, cmd_valid, cmd_ready, rsp_valid, ok, stall_abs_en, stall_delta_en;
  logic temp_warn_cmp, temp_sd_cmp, vbat_uv_cmp, vbat_sd_cmp, vbat_recov_cmp, strap_address_pin, motion_active;
  logic decelerating_halt, motor_shutdown;
  logic [6:0] bus_address;
  logic [12:0] stall_abs_mv;
  logic [11:0] stall_delta_mv;
  logic [9:0] run_current_ma, hold_current_ma;
  logic [4:0] microsteps;
  otpps_pkg::otpps_cmd_t cmd_in, c;
  otpps_pkg::otpps_rsp_t rsp_out;
  otpps_pkg::otpps_flags_t flags_out;
  otpps_pkg::otpps_params_t work_params;
  int fail_count = 0, checked = 0, n;
  always #20 clk = ~clk;
  always #24 link_clk = ~link_clk;
  otpps_top #(.FACTORY_TRIM_A(TRIM)) DUT (.clk, .sys_rst, .link_clk, .cmd_in, .cmd_valid, .cmd_ready,
    .rsp_out, .rsp_valid, .factory_init, .temp_warn_cmp, .temp_sd_cmp, .vbat_uv_cmp, .vbat_sd_cmp,
    .vbat_recov_cmp, .strap_address_pin, .motion_active, .decelerating_halt, .motor_shutdown, .flags_out,
    .work_params, .bus_address, .stall_abs_en, .stall_abs_mv, .stall_delta_en, .stall_delta_mv,
    .run_current_ma, .hold_current_ma, .microsteps);
  otpps_mst u_mst (.link_clk, .cmd_ready, .rsp_valid, .cmd_in, .cmd_valid);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input otpps_pkg::otpps_cmd_e_t k, input logic [2:0] a, input logic [7:0] d);
    c = '{code: k, addr: a, byte_data: d, params: c.params};
    u_mst.issue(c, ok);
    chk(ok, 1'b1);
  endtask
  task automatic clks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("TB: %0d checks, %0d mismatches", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    close_out;
  end
  initial
  begin
    c = '0;
    {clk, link_clk, temp_warn_cmp, temp_sd_cmp, vbat_uv_cmp, vbat_sd_cmp, vbat_recov_cmp, motion_active} = 8'h00;
    {sys_rst, factory_init, strap_address_pin} = 3'h7;
    clks(3);
    factory_init = 1'b0;
    clks(5);
    sys_rst = 1'b0;
    clks(4);
    chk(microsteps, 5'h02);
    cmd(RDB, 3'h7, 8'h00);
    chk(rsp_out.byte_data, 8'h02);
    cmd(PRG, 3'h0, 8'hFF);
    chk(rsp_out.refused, 1'b1);
    cmd(RDB, 3'h0, 8'h00);
    chk(rsp_out.byte_data, TRIM);
    $display("TB: factory lock test done");
    cmd(PRG, 3'h3, 8'hE5);
    chk(rsp_out.refused, 1'b0);
    chk(run_current_ma, 10'h03B);
    cmd(RDB, 3'h3, 8'h00);
    chk(rsp_out.byte_data, 8'hE5);
    chk(run_current_ma, 10'h2A1);
    chk(hold_current_ma, 10'h08D);
    cmd(PRG, 3'h3, 8'h0A);
    cmd(otpps_pkg::CMD_RESTORE_DEFAULTS, 3'h0, 8'h00);
    chk(hold_current_ma, 10'h000);
    cmd(RDB, 3'h3, 8'h00);
    chk(rsp_out.byte_data, 8'hEF);
    cmd(PRG, 3'h2, 8'h15);
    cmd(PRG, 3'h7, 8'h9D);
    cmd(RDB, 3'h7, 8'h00);
    chk(rsp_out.byte_data, 8'h9F);
    chk(bus_address, 7'h6B);
    chk(stall_abs_mv, 13'h01F4);
    chk(stall_delta_mv, 12'h8CA);
    chk(stall_abs_en, 1'b1);
    chk(stall_delta_en, 1'b1);
    chk(microsteps, 5'h10);
    cmd(PRG, 3'h4, 8'h11);
    chk(rsp_out.refused, 1'b1);
    cmd(RDB, 3'h4, 8'h00);
    chk(rsp_out.byte_data, 8'h00);
    c.params = '0;
    c.params.run_current = 4'h3;
    cmd(otpps_pkg::CMD_MOTION_WRITE, 3'h0, 8'h00);
    chk(run_current_ma, 10'h064);
    chk(work_params.run_current, 4'h3);
    chk(cmd_ready, 1'b1);
    chk(bus_address, 7'h6B);
    $display("TB: program and lock test done");
    clks(1);
    motion_active = 1'b1;
    {temp_warn_cmp, temp_sd_cmp} = 2'h3;
    for (n = 0; n < 10 && decelerating_halt !== 1'b1; n++) @(negedge clk);
    chk(decelerating_halt, 1'b1);
    clks(1);
    motion_active = 1'b0;
    clks(3);
    chk(motor_shutdown, 1'b1);
    chk(flags_out, 4'hC);
    cmd(STS, 3'h0, 8'h00);
    chk(flags_out, 4'hC);
    clks(1);
    {temp_warn_cmp, temp_sd_cmp} = 2'h0;
    clks(4);
    cmd(STS, 3'h0, 8'h00);
    chk(rsp_out.flags, 4'hC);
    chk(flags_out, 4'h0);
    $display("TB: thermal test done");
    clks(1);
    {vbat_uv_cmp, vbat_sd_cmp, motion_active} = 3'h7;
    clks(5);
    {vbat_uv_cmp, vbat_sd_cmp, motion_active} = 3'h0;
    clks(4);
    chk(flags_out, 4'h3);
    cmd(STS, 3'h0, 8'h00);
    chk(flags_out, 4'h3);
    clks(1);
    vbat_recov_cmp = 1'b1;
    clks(4);
    cmd(STS, 3'h0, 8'h00);
    chk(flags_out, 4'h0);
    $display("TB: battery test done");
    close_out;
  end
endmodule
`default_nettype wire
